// ### logic/tdcr_cfg.svh
`ifndef TDCR_CFG_SVH
`define TDCR_CFG_SVH

`define TDCR_ADDR_ACQ       8'h01
`define TDCR_ADDR_LA        8'h03
`define TDCR_ADDR_BWC       8'h05
`define TDCR_ADDR_BCLS      8'h07
`define TDCR_ADDR_BPTR      8'h10
`define TDCR_ADDR_TCC       8'h12
`define TDCR_ACQ_RST        32'h0000_0000
`define TDCR_ACQ_WMASK      32'hef9f_00ff
`define TDCR_LA_RST         16'h0000
`define TDCR_BWC_RST        11'h000
`define TDCR_BCLS_RST       4'h0
`define TDCR_BPTR_RST       16'h0700
`define TDCR_TCC_RST        16'h0000
`define TDCR_CLK_NS         8
`define TDCR_TW0_NS         125
`define TDCR_TW1_NS         250
`define TDCR_TW2_NS         1000
`define TDCR_TW3_NS         2000
`define TDCR_TO_BASE_NS     64
`define TDCR_TO_MAX_SHIFT   4'h9
`define TDCR_FCW_STEP_NS    128
`define TDCR_CYC_UP(ns)     (((ns) + `TDCR_CLK_NS - 1) / `TDCR_CLK_NS)
`endif

// ### logic/tdcr_pkg.sv
package tdcr_pkg;

  typedef struct packed {
    logic       start_mode;
    logic       rise_en;
    logic       fall_en;
    logic       rsv28;
    logic [3:0] clear_win;
    logic       tester_en;
    logic [1:0] rsv22;
    logic       sparse_en;
    logic [1:0] test_width;
    logic [1:0] burst;
    logic [7:0] rsv8;
    logic [3:0] timeout;
    logic       clr_tr0;
    logic       fcw_tr5;
    logic       com_bp;
    logic       busy_tr7;
  } tdcr_acq_t;

  typedef struct packed {
    logic [7:0] rd;
    logic [7:0] wr;
  } tdcr_bptr_t;

  typedef struct packed {
    logic [11:0] full_scale;
    logic [3:0]  lifo_depth;
  } tdcr_tcc_t;

  typedef struct packed {
    logic front_com;
    logic tr6;
    logic tr3;
    logic front_clr;
    logic tr0;
    logic tr5;
  } tdcr_pins_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ACCEPT, ST_WINDOW} tdcr_state_t;

endpackage

// ### logic/tdcr_regs.sv
`timescale 1ns/1ns
`include "tdcr_cfg.svh"
module tdcr_regs
  import tdcr_pkg::*;
#(
  parameter int WC_W = 11
)
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire logic              master_reset,
  input  wire logic              mem_test_mode,
  input  wire logic              simple_sparse_sel,
  input  wire logic              test_cycle,
  input  wire logic              internal_com,
  input  wire logic              fast_clear_cmd,
  input  wire logic              advance_event,
  input  wire logic              block_word_xfer,
  input  wire logic [WC_W-1:0]   next_word_count,
  input  wire tdcr_pins_t        pins_in,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  output logic                   reg_ack,
  output logic                   start_mode,
  output logic                   rise_edge_en,
  output logic                   fall_edge_en,
  output logic                   sparse_en,
  output logic                   sparse_simple,
  output logic                   hit_accept,
  output logic                   tester_pulse,
  output logic                   event_clear,
  output logic                   event_commit,
  output logic                   buffering_busy_signal,
  output logic                   tr7_out,
  output logic                   tr7_oe,
  output logic      [15:0]       logical_address,
  output logic      [3:0]        broadcast_class_select,
  output logic      [2:0]        read_buf,
  output logic      [2:0]        next_read_buf,
  output logic      [2:0]        write_buf,
  output logic                   buf_empty,
  output logic                   buf_full,
  output logic      [WC_W-1:0]   block_words,
  output logic      [11:0]       full_scale,
  output logic      [3:0]        lifo_depth
);

  localparam int TO_BASE_CYC  = `TDCR_CYC_UP(`TDCR_TO_BASE_NS);
  localparam int FCW_STEP_CYC = `TDCR_CYC_UP(`TDCR_FCW_STEP_NS);
  tdcr_acq_t          acq_q;
  tdcr_bptr_t         bptr_q;
  tdcr_tcc_t          tcc_q;
  logic [15:0]        la_q;
  logic [WC_W-1:0]    bwc_q;
  logic [3:0]         bcls_q;
  tdcr_pins_t         s1_q, s2_q, s3_q, lvl_q, lvl_d, rise_v;
  tdcr_state_t        st_q;
  logic [12:0]        cnt_q;
  logic               clr_q, commit_q;
  logic               ts_act_q, ts_high_q;
  logic [7:0]         ts_cnt_q;
  logic [3:0]         ts_left_q;
  // register port decode
  wire hit_acq  = reg_addr == `TDCR_ADDR_ACQ;
  wire hit_la   = reg_addr == `TDCR_ADDR_LA;
  wire hit_bwc  = reg_addr == `TDCR_ADDR_BWC;
  wire hit_bcls = reg_addr == `TDCR_ADDR_BCLS;
  wire hit_bptr = reg_addr == `TDCR_ADDR_BPTR;
  wire hit_tcc  = reg_addr == `TDCR_ADDR_TCC;
  wire wr_bwc   = reg_wr & hit_bwc & mem_test_mode;
  wire wr_bptr  = reg_wr & hit_bptr;
  wire [31:0] rd_val =
    hit_acq  ? acq_q :
    hit_la   ? {la_q, 16'h0000} :
    (hit_bwc & mem_test_mode) ? {{(32-WC_W){1'b0}}, bwc_q} :
    hit_bcls ? {28'h0000000, bcls_q} :
    hit_bptr ? {16'h0000, bptr_q} :
    hit_tcc  ? {16'h0000, tcc_q} :
    32'h0000_0000;
  // pin filter: a level changes once stages two and three agree
  assign lvl_d  = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
  assign rise_v = lvl_d & ~lvl_q;
  wire com_pin = acq_q.com_bp ? (acq_q.start_mode ? rise_v.tr3 : rise_v.tr6)
                              : rise_v.front_com;
  wire com_evt = internal_com | com_pin;
  wire clear_window_input = acq_q.fcw_tr5 & lvl_q.tr5;
  wire clr_req = fast_clear_cmd | rise_v.front_clr | (acq_q.clr_tr0 & rise_v.tr0);
  // timeout doubles per code step from the base, saturating at code 9
  wire [3:0]  to_sh   = (acq_q.timeout > `TDCR_TO_MAX_SHIFT) ? `TDCR_TO_MAX_SHIFT : acq_q.timeout;
  wire [12:0] to_cyc  = 13'(TO_BASE_CYC) << to_sh;
  wire [12:0] fcw_cyc = 13'(({1'b0, acq_q.clear_win} + 5'h01) * FCW_STEP_CYC);
  wire [7:0] tw_cyc =
    (acq_q.test_width == 2'h0) ? 8'(`TDCR_CYC_UP(`TDCR_TW0_NS)) :
    (acq_q.test_width == 2'h1) ? 8'(`TDCR_CYC_UP(`TDCR_TW1_NS)) :
    (acq_q.test_width == 2'h2) ? 8'(`TDCR_CYC_UP(`TDCR_TW2_NS)) :
                                 8'(`TDCR_CYC_UP(`TDCR_TW3_NS));
  wire [3:0] ts_pulses = 4'h1 << acq_q.burst;
  wire [2:0] rd3 = bptr_q.rd[2:0];
  wire [2:0] wr3 = bptr_q.wr[2:0];
  assign buf_empty = (rd3 + 3'h1) == wr3;
  assign buf_full  = rd3 == wr3;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end
    else if (ce)
    begin
      s1_q  <= pins_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      reg_rdata <= 32'h0000_0000;
      reg_ack   <= 1'b0;
    end
    else if (ce)
    begin
      reg_ack   <= reg_wr | reg_rd;
      reg_rdata <= reg_rd ? rd_val : 32'h0000_0000;
    end
  end

  // configuration registers; logical address and classes also clear on master reset
  always_ff @(posedge mclk)
  begin
    if (reset | (ce & master_reset))
    begin
      acq_q  <= `TDCR_ACQ_RST;
      la_q   <= `TDCR_LA_RST;
      bcls_q <= `TDCR_BCLS_RST;
      tcc_q  <= `TDCR_TCC_RST;
    end
    else if (ce & reg_wr)
    begin
      if (hit_acq)
        acq_q <= reg_wdata & `TDCR_ACQ_WMASK;
      if (hit_la)
        la_q <= reg_wdata[31:16];
      if (hit_bcls)
        bcls_q <= reg_wdata[3:0];
      if (hit_tcc)
        tcc_q <= reg_wdata[15:0];
    end
  end

  // word counter and buffer pointers; a register write wins over hardware
  always_ff @(posedge mclk)
  begin
    if (reset | (ce & master_reset))
    begin
      bwc_q  <= `TDCR_BWC_RST;
      bptr_q <= `TDCR_BPTR_RST;
    end
    else if (ce)
    begin
      if (wr_bwc)
        bwc_q <= reg_wdata[WC_W-1:0];
      else if (advance_event)
        bwc_q <= next_word_count;
      else if (block_word_xfer && bwc_q != '0)
        bwc_q <= bwc_q - 1'b1;
      if (wr_bptr)
        bptr_q <= reg_wdata[15:0];
      else
      begin
        if (advance_event)
          bptr_q.rd <= {5'h00, rd3 + 3'h1};
        if (commit_q)
          bptr_q.wr <= {5'h00, wr3 + 3'h1};
      end
    end
  end

  // acquisition and clear window sequencer
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_q     <= ST_IDLE;
      cnt_q    <= '0;
      clr_q    <= 1'b0;
      commit_q <= 1'b0;
    end
    else if (ce)
    begin
      clr_q    <= 1'b0;
      commit_q <= 1'b0;
      case (st_q)
        ST_IDLE:
          if (com_evt && !buf_full)
          begin
            st_q  <= acq_q.start_mode ? ST_ACCEPT : ST_WINDOW;
            cnt_q <= (acq_q.start_mode ? to_cyc : fcw_cyc) - 13'h0001;
          end
        ST_ACCEPT:
          if (clr_req && clear_window_input)
          begin
            clr_q <= 1'b1;
            st_q  <= ST_IDLE;
          end
          else if (cnt_q == '0)
          begin
            st_q  <= ST_WINDOW;
            cnt_q <= fcw_cyc - 13'h0001;
          end
          else
            cnt_q <= cnt_q - 13'h0001;
        ST_WINDOW:
          if (clr_req)
          begin
            clr_q <= 1'b1;
            st_q  <= ST_IDLE;
          end
          else if (cnt_q == '0 && !clear_window_input)
          begin
            commit_q <= 1'b1;
            st_q     <= ST_IDLE;
          end
          else if (cnt_q != '0)
            cnt_q <= cnt_q - 13'h0001;
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // internal tester: burst of pulses, low time equal to high time
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ts_act_q  <= 1'b0;
      ts_high_q <= 1'b0;
      ts_cnt_q  <= '0;
      ts_left_q <= '0;
    end
    else if (ce)
    begin
      if (!ts_act_q)
      begin
        if (test_cycle && acq_q.tester_en)
        begin
          ts_act_q  <= 1'b1;
          ts_high_q <= 1'b1;
          ts_cnt_q  <= tw_cyc - 8'h01;
          ts_left_q <= ts_pulses - 4'h1;
        end
      end
      else if (ts_cnt_q != '0)
        ts_cnt_q <= ts_cnt_q - 8'h01;
      else if (ts_high_q)
      begin
        ts_high_q <= 1'b0;
        ts_cnt_q  <= tw_cyc - 8'h01;
        if (ts_left_q == '0)
          ts_act_q <= 1'b0;
      end
      else
      begin
        ts_high_q <= 1'b1;
        ts_cnt_q  <= tw_cyc - 8'h01;
        ts_left_q <= ts_left_q - 4'h1;
      end
    end
  end

  assign start_mode             = acq_q.start_mode;
  assign rise_edge_en           = acq_q.rise_en;
  assign fall_edge_en           = acq_q.fall_en;
  assign sparse_en              = acq_q.sparse_en;
  assign sparse_simple          = acq_q.sparse_en & simple_sparse_sel;
  assign hit_accept             = acq_q.start_mode ? (st_q == ST_ACCEPT)
                                                   : (st_q == ST_IDLE) & !buf_full;
  assign tester_pulse           = ts_high_q;
  assign event_clear            = clr_q;
  assign event_commit           = commit_q;
  assign buffering_busy_signal  = (st_q != ST_IDLE) | buf_full;
  assign tr7_out                = buffering_busy_signal;
  assign tr7_oe                 = acq_q.busy_tr7;
  assign logical_address        = la_q;
  assign broadcast_class_select = bcls_q;
  assign read_buf               = rd3;
  assign next_read_buf          = rd3 + 3'h1;
  assign write_buf              = wr3;
  assign block_words            = bwc_q;
  assign full_scale             = tcc_q.full_scale;
  assign lifo_depth             = tcc_q.lifo_depth;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_mode_write: assert property (ce && reg_wr && hit_acq && !master_reset
    |=> start_mode == $past(reg_wdata[31])) else $error("mode bit not stored");
  a_edge_readback: assert property (ce && reg_rd && hit_acq
    |=> reg_rdata[30:29] == $past({rise_edge_en, fall_edge_en}))
    else $error("edge bits read back wrong");
  a_ext_window_or: assert property (ce && st_q == ST_WINDOW && clr_req
    |=> event_clear && st_q == ST_IDLE) else $error("clear in window lost");
  a_late_clear: assert property (ce && st_q == ST_IDLE
    |=> !event_clear) else $error("clear outside any window");
  a_timeout_end: assert property (ce && st_q == ST_ACCEPT && cnt_q == '0
    && !(clr_req && clear_window_input) |=> st_q == ST_WINDOW)
    else $error("timeout did not open window");
  a_bwc_hidden: assert property (ce && reg_rd && hit_bwc && !mem_test_mode
    |=> reg_rdata == 32'h0000_0000) else $error("counter visible outside test");
  a_bwc_load: assert property (ce && advance_event && !wr_bwc && !master_reset
    |=> block_words == $past(next_word_count)) else $error("word count not loaded");
  a_ptr_advance: assert property (ce && advance_event && !wr_bptr && !master_reset
    |=> read_buf == $past(rd3) + 3'h1) else $error("read pointer not advanced");
  a_la_keep: assert property (!(ce && (master_reset || (reg_wr && hit_la)))
    |=> $stable(logical_address)) else $error("logical address changed");
  a_class_keep: assert property (!(ce && (master_reset || (reg_wr && hit_bcls)))
    |=> $stable(broadcast_class_select)) else $error("class bits changed");
  a_busy_gate: assert property (!acq_q.busy_tr7 |-> !tr7_oe)
    else $error("busy driven while disabled");
  a_empty_full: assert property (ce && master_reset |=> buf_empty && !buf_full)
    else $error("reset pointers not empty");

  c_commit: cover property (ce && event_commit);
  c_clear: cover property (ce && event_clear);
  c_burst: cover property (ce && ts_act_q && ts_left_q == 4'h7);
  c_full: cover property (buf_full);

endmodule

// ### tb/tdcr_acquisition_control_regs_tb.sv
`timescale 1ns/1ns
`include "tdcr_cfg.svh"
module tdcr_acquisition_control_regs_tb
  import tdcr_pkg::*;
;
  logic        mclk, reset, ce, master_reset, mem_test_mode, simple_sparse_sel;
  logic        test_cycle, internal_com, fast_clear_cmd, advance_event, block_word_xfer;
  logic [10:0] next_word_count, block_words, nwc;
  tdcr_pins_t  pins_in;
  logic [7:0]  reg_addr;
  logic        reg_wr, reg_rd, reg_ack, start_mode, rise_edge_en, fall_edge_en;
  logic        sparse_en, sparse_simple, hit_accept, tester_pulse, event_clear;
  logic        event_commit, buffering_busy_signal, tr7_out, tr7_oe, buf_empty, buf_full;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [15:0] logical_address;
  logic [3:0]  broadcast_class_select, lifo_depth;
  logic [2:0]  read_buf, next_read_buf, write_buf;
  logic [11:0] full_scale;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int          fails, checks, n_clr, n_com, n_acc, n_tp, n_rise, t_com, t0;
  int          tw[4] = '{16, 32, 125, 250};

  tdcr_regs u_tdcr_regs (.mclk(mclk), .reset(reset), .ce(ce), .master_reset(master_reset),
    .mem_test_mode(mem_test_mode), .simple_sparse_sel(simple_sparse_sel),
    .test_cycle(test_cycle), .internal_com(internal_com), .fast_clear_cmd(fast_clear_cmd),
    .advance_event(advance_event), .block_word_xfer(block_word_xfer),
    .next_word_count(next_word_count), .pins_in(pins_in), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .start_mode(start_mode), .rise_edge_en(rise_edge_en),
    .fall_edge_en(fall_edge_en), .sparse_en(sparse_en), .sparse_simple(sparse_simple),
    .hit_accept(hit_accept), .tester_pulse(tester_pulse), .event_clear(event_clear),
    .event_commit(event_commit), .buffering_busy_signal(buffering_busy_signal),
    .tr7_out(tr7_out), .tr7_oe(tr7_oe), .logical_address(logical_address),
    .broadcast_class_select(broadcast_class_select), .read_buf(read_buf),
    .next_read_buf(next_read_buf), .write_buf(write_buf), .buf_empty(buf_empty),
    .buf_full(buf_full), .block_words(block_words), .full_scale(full_scale),
    .lifo_depth(lifo_depth));
  tdcr_master u_tdcr_master (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));

  always #4 mclk = ~mclk;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s exp %h got %h", nm, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // s: 0 com, 1 clear, 2 tester, 3 word xfer, 4 advance, 5 master reset
  task automatic pulse(input int s);
    @(posedge mclk);
    {internal_com, fast_clear_cmd, test_cycle, block_word_xfer, advance_event,
      master_reset} <= 6'h20 >> s;
    @(posedge mclk);
    {internal_com, fast_clear_cmd, test_cycle, block_word_xfer, advance_event,
      master_reset} <= 6'h00;
  endtask

  // counts output activity over a fixed span
  task automatic watch(input int n);
    logic p;
    p = tester_pulse;
    {n_clr, n_com, n_acc, n_tp, n_rise} = '0;
    t_com = -1;
    for (int k = 0; k < n; k++)
    begin
      @(posedge mclk);
      n_clr += (event_clear === 1'b1);
      n_acc += (hit_accept === 1'b1);
      n_tp += (tester_pulse === 1'b1);
      n_rise += (tester_pulse === 1'b1 && p === 1'b0);
      p = tester_pulse;
      if (event_commit === 1'b1)
      begin
        n_com++;
        if (t_com < 0)
          t_com = k;
      end
    end
  endtask

  always @(posedge mclk)
    if (reg_ack === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("reg_ack", 1'b1, 1'b0);
      else
      begin
        e = exp_q.pop_front();
        if (e[32])
          check("reg_rdata", reg_rdata, e[31:0]);
      end
    end

  initial
  begin
    repeat (100000) @(posedge mclk);
    fails++;
    results();
  end

  initial
  begin
    mclk = 1'b0;
    reset = 1'b1;
    ce = 1'b1;
    {master_reset, mem_test_mode, test_cycle, internal_com, fast_clear_cmd} = '0;
    {advance_event, block_word_xfer} = '0;
    simple_sparse_sel = 1'b1;
    next_word_count = 11'h000;
    pins_in = '0;
    void'($urandom(40724));
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    mem_test_mode <= 1'b1;
    u_tdcr_master.rd(8'h01, 32'h0);
    u_tdcr_master.rd(8'h03, 32'h0);
    u_tdcr_master.rd(8'h05, 32'h0);
    u_tdcr_master.rd(8'h07, 32'h0);
    u_tdcr_master.rd(8'h10, 32'h0000_0700);
    u_tdcr_master.rd(8'h12, 32'h0);
    u_tdcr_master.rd(8'h02, 32'h0);
    check("buf_empty", buf_empty, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      v = (i == 4) ? 32'hffff_ffff : $urandom();
      v = v & `TDCR_ACQ_WMASK;
      u_tdcr_master.wr(8'h01, v);
      u_tdcr_master.rd(8'h01, v);
      check("start_mode", start_mode, v[31]);
      check("edges", {rise_edge_en, fall_edge_en}, v[30:29]);
      check("sparse", {sparse_en, sparse_simple}, {2{v[20]}});
      check("tr7_oe", tr7_oe, v[0]);
    end
    u_tdcr_master.wr(8'h03, 32'hffff_ffff);
    u_tdcr_master.rd(8'h03, 32'hffff_0000);
    u_tdcr_master.wr(8'h07, 32'hffff_ffff);
    u_tdcr_master.rd(8'h07, 32'h0000_000f);
    u_tdcr_master.wr(8'h12, 32'hffff_fff5);
    u_tdcr_master.rd(8'h12, 32'h0000_fff5);
    check("tcc", {full_scale, lifo_depth, broadcast_class_select}, 20'hfff5f);
    check("la", logical_address, 16'hffff);
    mem_test_mode <= 1'b0;
    u_tdcr_master.wr(8'h05, 32'h0000_0005);
    u_tdcr_master.rd(8'h05, 32'h0);
    mem_test_mode <= 1'b1;
    u_tdcr_master.rd(8'h05, 32'h0);
    u_tdcr_master.wr(8'h05, 32'hffff_ffff);
    u_tdcr_master.rd(8'h05, 32'h0000_07ff);
    u_tdcr_master.wr(8'h05, 32'h0000_0005);
    pulse(3);
    pulse(3);
    u_tdcr_master.rd(8'h05, 32'h0000_0003);
    nwc = 11'($urandom());
    next_word_count <= nwc;
    pulse(4);
    u_tdcr_master.rd(8'h05, {21'h0, nwc});
    check("adv", {read_buf, block_words, buf_full}, {3'd0, nwc, 1'b1});
    check("next", next_read_buf, 3'd1);
    check("busy", {buffering_busy_signal, tr7_out}, 2'b11);
    u_tdcr_master.wr(8'h10, 32'hffff_0304);
    u_tdcr_master.rd(8'h10, 32'h0000_0304);
    check("empty", buf_empty, 1'b1);
    pulse(5);
    u_tdcr_master.rd(8'h10, 32'h0000_0700);
    u_tdcr_master.rd(8'h01, 32'h0);
    u_tdcr_master.rd(8'h03, 32'h0);
    for (int c = 0; c < 4; c += 3)
    begin
      u_tdcr_master.wr(8'h01, (c << 24) | 1);
      pulse(0);
      watch(150);
      check("commit", n_com, 1);
      if (c == 0)
        t0 = t_com;
    end
    check("window", t_com - t0, 48);
    check("write_buf", write_buf, 3'd2);
    pulse(0);
    // sequencer state settles after the edge that takes the common
    @(negedge mclk);
    check("busy", {buffering_busy_signal, tr7_out, tr7_oe}, 3'b111);
    pulse(1);
    watch(150);
    check("clr", {n_clr[15:0], n_com[15:0]}, {16'd1, 16'd0});
    pulse(0);
    watch(150);
    pulse(1);
    watch(20);
    check("late clr", {n_clr[15:0], n_com[15:0]}, {16'd0, 16'd0});
    u_tdcr_master.wr(8'h01, 32'h0000_0004);
    pins_in.tr5 <= 1'b1;
    pulse(0);
    watch(150);
    check("ext hold", n_com, 0);
    pulse(1);
    watch(20);
    check("ext clr", n_clr, 1);
    pins_in.tr5 <= 1'b0;
    u_tdcr_master.wr(8'h01, 32'h0000_0008);
    pulse(0);
    pins_in.tr0 <= 1'b1;
    watch(40);
    check("tr0 clr", n_clr, 1);
    pins_in.tr0 <= 1'b0;
    u_tdcr_master.wr(8'h01, 32'h0000_0002);
    pins_in.front_com <= 1'b1;
    watch(40);
    check("front off", n_com, 0);
    pins_in.tr6 <= 1'b1;
    watch(60);
    check("tr6 com", n_com, 1);
    pins_in <= '0;
    for (int c = 0; c < 3; c++)
    begin
      u_tdcr_master.wr(8'h01, 32'h8000_0000 | (c << 4));
      pulse(0);
      watch(300);
      check("accept", {n_acc[15:0], n_com[15:0]}, {16'(8 << c), 16'd1});
    end
    check("full", {write_buf, buf_full}, {3'd7, 1'b1});
    pulse(0);
    watch(300);
    check("full com", n_com, 0);
    for (int w = 0; w < 4; w++)
    begin
      u_tdcr_master.wr(8'h01, 32'h0080_0000 | (w << 18) | (w << 16));
      pulse(2);
      watch((2 * tw[w] << w) + 60);
      check("tester", {n_tp[15:0], n_rise[15:0]}, {16'(tw[w] << w), 16'(1 << w)});
    end
    u_tdcr_master.wr(8'h01, 32'h0);
    pulse(2);
    watch(60);
    check("tester off", n_tp, 0);
    check("queue", exp_q.size(), 0);
    results();
  end
endmodule

// ### tb/tdcr_master.sv
`timescale 1ns/1ns
module tdcr_master
(
  input  wire logic        mclk,
  output logic      [7:0]  reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [31:0] reg_wdata
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 32'h0000_0000;
  end
  // strobe stands for the one taking edge, then the lines are let go
  task automatic req(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= ~w;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    // released lines carry no stale value
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tdcr_acquisition_control_regs_tb.exp_q.push_back({1'b0, 32'h0000_0000});
    req(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    tdcr_acquisition_control_regs_tb.exp_q.push_back({1'b1, e});
    req(1'b0, a, ~e);
  endtask
endmodule
